// >>> verilog/eeprom_i2c_slave_access.sv
// Serial slave access to the nonvolatile memory with paged writes
`timescale 1ns/1ns
module eeprom_i2c_slave_access #(
  parameter int MEM_BYTES = elapsed_rec_pkg::MEM_BYTES_DFLT,
  parameter int FIFO_DEPTH = elapsed_rec_pkg::FIFO_DEPTH_DFLT,
  parameter int COMMIT_CYC = elapsed_rec_pkg::NV_COMMIT_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Serial bus pins, SDA open drain
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Status
  output logic nv_busy
);
  import elapsed_rec_pkg::*;

  localparam int AW = $clog2(MEM_BYTES);
  localparam int CW = $clog2(COMMIT_CYC + 1);
  localparam int FW = AW + 8;

  typedef struct packed {
    logic [MEM_BYTES-1:0][7:0] mem;
    proto_st_t state;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [AW-1:0] addr_cnt;
    logic first;
    logic is_write;
    logic wrote;
    logic drain;
    logic ack_rx;
    logic sda_oe;
    logic [CW-1:0] busy_cnt;
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
  } acc_st_t;

  acc_st_t r;
  acc_st_t n;
  logic push_valid;
  logic [FW-1:0] push_data;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [FW-1:0] fifo_out_data;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  // Next location inside the same row, low bits wrap
  function automatic logic [AW-1:0] row_next(input logic [AW-1:0] a);
    row_next = {a[AW-1:ROW_BITS], a[ROW_BITS-1:0] + 1'b1};
  endfunction : row_next

  // Next location across the whole array
  function automatic logic [AW-1:0] lin_next(input logic [AW-1:0] a);
    lin_next = a + 1'b1;
  endfunction : lin_next

  // Edges and conditions seen on the synchronised pins only
  assign scl_rise = r.scl_s & ~r.scl_d;
  assign scl_fall = ~r.scl_s & r.scl_d;
  assign bus_start = r.scl_s & r.scl_d & r.sda_d & ~r.sda_s;
  assign bus_stop = r.scl_s & r.scl_d & ~r.sda_d & r.sda_s;

  // Pin drive: open drain, only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe = r.sda_oe;
  assign nv_busy = (r.busy_cnt != '0);

  // Received bytes wait here until the transaction closes
  wr_fifo #(
    .W(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_valid(push_valid),
    .in_ready(fifo_in_ready),
    .in_data(push_data),
    .out_valid(fifo_out_valid),
    .out_ready(r.drain),
    .out_data(fifo_out_data)
  );

  // Protocol engine, commit timer and buffer drain
  always_comb begin
    logic load_rd;
    load_rd = 1'b0;
    n = r;
    push_valid = 1'b0;
    push_data = {r.addr_cnt, r.shreg};
    // Two flops per pin, third stage only for edge detection
    n.scl_m = scl_i;
    n.scl_s = r.scl_m;
    n.scl_d = r.scl_s;
    n.sda_m = sda_i;
    n.sda_s = r.sda_m;
    n.sda_d = r.sda_s;
    if (r.busy_cnt != '0) begin
      n.busy_cnt = r.busy_cnt - 1'b1;
    end
    // Drain buffered bytes into the array once the transaction closed
    if (r.drain && fifo_out_valid) begin
      n.mem[fifo_out_data[FW-1:8]] = fifo_out_data[7:0];
    end
    if (r.drain && !fifo_out_valid) begin
      n.drain = 1'b0;
    end
    if (bus_start) begin
      // Repeated START: apply the data but no commit delay
      if (r.wrote) begin
        n.drain = 1'b1;
      end
      n.wrote = 1'b0;
      n.state = ST_ADDR;
      n.bitcnt = '0;
      n.sda_oe = 1'b0;
    end else if (bus_stop) begin
      // STOP after data: drain and hold off the bus for the commit
      if (r.wrote) begin
        n.drain = 1'b1;
        n.busy_cnt = CW'(COMMIT_CYC);
      end
      n.wrote = 1'b0;
      n.state = ST_IDLE;
      n.sda_oe = 1'b0;
    end else begin
      case (r.state)
        ST_ADDR, ST_WR: begin
          if (scl_rise) begin
            n.shreg = {r.shreg[6:0], r.sda_s};
            n.bitcnt = r.bitcnt + 1'b1;
          end
          if (scl_fall && r.bitcnt == BYTE_BITS) begin
            n.bitcnt = '0;
            n.state = ST_SKIP;
            if (r.state == ST_ADDR) begin
              // Own address acknowledged only when not committing
              if (r.shreg[7:1] == SLAVE_ADDR && r.busy_cnt == '0) begin
                n.sda_oe = 1'b1;
                n.is_write = ~r.shreg[0];
                n.first = 1'b1;
                n.state = ST_ACK;
              end
            end else if (r.first) begin
              // First byte after a write address sets the counter
              n.addr_cnt = r.shreg[AW-1:0];
              n.first = 1'b0;
              n.sda_oe = 1'b1;
              n.state = ST_ACK;
            end else if (fifo_in_ready) begin
              // Full buffer refuses the byte with a NACK
              push_valid = 1'b1;
              n.addr_cnt = row_next(r.addr_cnt);
              n.wrote = 1'b1;
              n.sda_oe = 1'b1;
              n.state = ST_ACK;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            n.bitcnt = '0;
            if (r.is_write) begin
              n.sda_oe = 1'b0;
              n.state = ST_WR;
            end else begin
              load_rd = 1'b1;
            end
          end
        end
        ST_RD: begin
          if (scl_rise) begin
            n.bitcnt = r.bitcnt + 1'b1;
          end
          if (scl_fall) begin
            if (r.bitcnt == BYTE_BITS) begin
              n.sda_oe = 1'b0;
              n.state = ST_MACK;
            end else begin
              n.shreg = {r.shreg[6:0], 1'b1};
              n.sda_oe = ~r.shreg[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            n.ack_rx = ~r.sda_s;
          end
          if (scl_fall) begin
            n.bitcnt = '0;
            if (r.ack_rx) begin
              load_rd = 1'b1;
            end else begin
              n.state = ST_SKIP;
            end
          end
        end
        ST_IDLE, ST_SKIP: begin
          n.sda_oe = 1'b0;
        end
        default: begin
          n.state = ST_IDLE;
          n.sda_oe = 1'b0;
        end
      endcase
    end
    // Fetch at the counter and present the first bit
    if (load_rd) begin
      n.shreg = r.mem[r.addr_cnt];
      n.sda_oe = ~r.mem[r.addr_cnt][7];
      n.addr_cnt = lin_next(r.addr_cnt);
      n.state = ST_RD;
    end
  end

  // State register; array resets to the erased pattern
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      r <= '0;
      r.mem <= {MEM_BYTES{MEM_ERASED}};
      r.state <= ST_IDLE;
      r.scl_m <= BUS_IDLE;
      r.scl_s <= BUS_IDLE;
      r.scl_d <= BUS_IDLE;
      r.sda_m <= BUS_IDLE;
      r.sda_s <= BUS_IDLE;
      r.sda_d <= BUS_IDLE;
    end else begin
      r <= n;
    end
  end
endmodule : eeprom_i2c_slave_access

// >>> shared/elapsed_rec_pkg.sv
// Constants, types and reset values for the serial slave access block
// Functional notes
// - One write transaction stays within one row
// - Counter advances after each received data byte
// - Counter wraps to start of same row
// - STOP after data starts the nonvolatile commit
// - Own address not acknowledged while committing
// - Reads start at current counter value
// - Dummy write loads counter before read
// - Each master ACK fetches the next byte
// - Responds to slave address D6h/D7h
// - Second byte of a write is memory address
// - Repeated START updates without commit delay
// - Foreign address ignored until next START
package elapsed_rec_pkg;
  // Slave address, upper seven bits of D6h
  localparam logic [6:0] SLAVE_ADDR = 7'h6B;
  // Byte framing
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int ROW_BITS = 3;
  // Memory geometry and write buffer
  localparam int MEM_BYTES_DFLT = 64;
  localparam int FIFO_DEPTH_DFLT = 32;
  // Timing: clock period and commit time in their own units
  localparam int MCLK_PERIOD_NS = 8;
  localparam int NV_COMMIT_TIME_NS = 10000000;
  localparam int NV_COMMIT_CYC = (NV_COMMIT_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  // Values after reset
  localparam logic [7:0] MEM_ERASED = 8'hFF;
  localparam logic BUS_IDLE = 1'b1;

  // Protocol states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_ACK = 7'h04,
    ST_WR = 7'h08,
    ST_RD = 7'h10,
    ST_MACK = 7'h20,
    ST_SKIP = 7'h40
  } proto_st_t;
endpackage : elapsed_rec_pkg

// >>> verilog/wr_fifo.sv
// Synchronous FIFO holding received address/data pairs until STOP or repeated START
`timescale 1ns/1ns
module wr_fifo #(
  parameter int W = 14,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] slots;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } fifo_st_t;

  fifo_st_t r;
  fifo_st_t n;
  logic do_push;
  logic do_pop;

  // Honest full and empty from the occupancy count
  assign in_ready = (r.cnt != (PW+1)'(DEPTH));
  assign out_valid = (r.cnt != '0);
  assign out_data = r.slots[r.rp];
  assign do_push = in_valid & in_ready;
  assign do_pop = out_valid & out_ready;

  // Next state: pointers wrap naturally at a power-of-two depth
  always_comb begin
    n = r;
    if (do_push) begin
      n.slots[r.wp] = in_data;
      n.wp = r.wp + 1'b1;
    end
    if (do_pop) begin
      n.rp = r.rp + 1'b1;
    end
    if (do_push && !do_pop) begin
      n.cnt = r.cnt + 1'b1;
    end else if (do_pop && !do_push) begin
      n.cnt = r.cnt - 1'b1;
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule : wr_fifo

// >>> dv/eeprom_i2c_slave_access_assertions.sv
// Port checks for the serial slave access block
`timescale 1ns/1ns
module eeprom_i2c_slave_access_assertions #(
  parameter int COMMIT_CYC = 50
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Bus pins and status
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic nv_busy
);
  int busy_cnt_r;
  // Busy span length, read back at the fall
  always_ff @(posedge mclk) begin
    busy_cnt_r <= (sys_rst || !nv_busy) ? 0 : busy_cnt_r + 1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_pin_open_drain: assert property (sda_o == 1'b0)
    else $error("sda_o high");
  a_oe_rise_low: assert property ($rose(sda_oe) |-> !scl_i)
    else $error("drive began with clock high");
  a_oe_fall_low: assert property ($fell(sda_oe) |-> !scl_i)
    else $error("release with clock high");
  a_oe_scl_high: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe))
    else $error("data moved with clock high");
  a_busy_at_stop: assert property ($rose(nv_busy) |-> scl_i && sda_i)
    else $error("busy without stop");
  a_busy_hold: assert property ($rose(nv_busy) |=> nv_busy [*8])
    else $error("busy too short");
  a_busy_exact: assert property ($fell(nv_busy) |-> busy_cnt_r == COMMIT_CYC)
    else $error("busy length wrong");
  a_busy_silent: assert property (nv_busy |-> !sda_oe)
    else $error("driven while busy");
  // Main scenarios reached
  c_commit: cover property ($rose(nv_busy));
  c_drive: cover property ($rose(sda_oe));
  c_done: cover property ($fell(nv_busy));
endmodule : eeprom_i2c_slave_access_assertions

// >>> dv/bus_master.sv
// Behavioural bus master driving clock and data against the slave
`timescale 1ns/1ns
module bus_master (
  // Clock
  input wire logic mclk,
  // Resolved data level, driven clock, data pull-down
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  localparam int HALF = 8;
  // Idle bus: clock high, data released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Falling-edge waits keep changes away from the sampling edge
  task automatic hold(input int n);
    repeat (n) @(negedge mclk);
  endtask : hold
  // Data set in the low phase, held through the high phase
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    r = sda;
    scl = 1'b0;
    hold(2);
  endtask : bit_io
  // Start or repeated start, whatever the clock level on entry
  task automatic start();
    sda_low = 1'b0;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    sda_low = 1'b1;
    hold(HALF);
    scl = 1'b0;
    hold(2);
  endtask : start
  // Stop leaves the bus released
  task automatic stop();
    sda_low = 1'b1;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    sda_low = 1'b0;
    hold(HALF);
  endtask : stop
  // Byte out, MSB first, then the slave answer
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : wbyte
  // Byte in; the last one is refused to end the read
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!more, r);
  endtask : rbyte
endmodule : bus_master

// >>> dv/testbench.sv
// Self-checking bench for the serial slave access block
`timescale 1ns/1ns
module testbench;
  import elapsed_rec_pkg::*;
  localparam int CYC = 400;
  localparam logic [7:0] WA = {SLAVE_ADDR, 1'b0};
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic scl, sda_low, sda, sda_o, sda_oe, nv_busy;
  logic [7:0] mem [64];
  logic [5:0] ptr;
  int err_total = 0;
  int compares = 0;
  // 125 MHz clock and pulled-up data wire
  always #4 mclk = ~mclk;
  assign sda = !(sda_low || (sda_oe && !sda_o));
  eeprom_i2c_slave_access #(.COMMIT_CYC(CYC)) eeprom_i2c_slave_access_inst (.mclk(mclk),
    .sys_rst(sys_rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .nv_busy(nv_busy));
  bus_master bm (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));
  // Write counter stays inside its row
  function automatic logic [5:0] nxt(input logic [5:0] a);
    return {a[5:3], a[2:0] + 3'h1};
  endfunction : nxt
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    compares++;
    if (got !== want) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, want);
    end
  endtask : chk
  task automatic conclude();
    if (err_total == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  // Poll the address; first try refused only while busy
  task automatic poll();
    logic ack;
    logic b;
    int k;
    b = nv_busy;
    k = 0;
    do begin
      bm.start();
      bm.wbyte(WA, ack);
      bm.stop();
      if (k == 0) chk(8'(ack), 8'(!b));
      k++;
    end while (!ack && k < 20);
    chk(8'(ack), 8'h01);
  endtask : poll
  task automatic wr(input logic [5:0] a, input int n, input bit sr);
    logic ack;
    logic [7:0] d;
    bm.start();
    bm.wbyte(WA, ack);
    chk(8'(ack), 8'h01);
    bm.wbyte({2'h0, a}, ack);
    chk(8'(ack), 8'h01);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      bm.wbyte(d, ack);
      chk(8'(ack), 8'(i < FIFO_DEPTH_DFLT));
      if (i < FIFO_DEPTH_DFLT) begin
        mem[a] = d;
        a = nxt(a);
      end
    end
    ptr = a;
    if (sr) begin
      bm.start();
      chk(8'(nv_busy), 8'h00);
    end else begin
      bm.stop();
      chk(8'(nv_busy), 8'h01);
      poll();
    end
  endtask : wr
  task automatic rd(input logic [5:0] a, input bit dummy, input bit cont, input int n);
    logic ack;
    logic [7:0] d;
    if (!cont) bm.start();
    if (dummy) begin
      bm.wbyte(WA, ack);
      bm.wbyte({2'h0, a}, ack);
      bm.start();
      ptr = a;
    end
    bm.wbyte({SLAVE_ADDR, 1'b1}, ack);
    chk(8'(ack), 8'h01);
    for (int i = 0; i < n; i++) begin
      bm.rbyte(i < n - 1, d);
      chk(d, mem[ptr]);
      ptr = ptr + 6'h1;
    end
    bm.stop();
  endtask : rd
  // Corner cases first, then random traffic
  initial begin
    logic ack;
    for (int i = 0; i < 64; i++) mem[i] = MEM_ERASED;
    ptr = 6'h00;
    void'($urandom(20));
    repeat (4) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (8) @(negedge mclk);
    rd(6'h00, 0, 0, 2);
    wr(6'h06, 3, 0);
    rd(6'h06, 1, 0, 3);
    rd(6'h00, 1, 0, 1);
    wr(6'h13, 34, 0);
    rd(6'h10, 1, 0, 8);
    wr(6'h2A, 4, 1);
    rd(6'h00, 0, 1, 3);
    bm.start();
    bm.wbyte({SLAVE_ADDR ^ 7'($urandom_range(1, 127)), 1'b0}, ack);
    chk(8'(ack), 8'h00);
    bm.wbyte(8'h00, ack);
    chk(8'(ack), 8'h00);
    bm.stop();
    chk(8'(nv_busy), 8'h00);
    for (int t = 0; t < 8; t++) begin
      ack = 1'($urandom);
      wr(6'($urandom), $urandom_range(1, 9), ack);
      rd(6'($urandom), 1'($urandom), ack, $urandom_range(1, 9));
    end
    conclude();
  end
  // Watchdog well beyond the expected run, still inside the cycle budget
  initial begin
    repeat (90000) @(posedge mclk);
    err_total++;
    conclude();
  end
endmodule : testbench
bind eeprom_i2c_slave_access eeprom_i2c_slave_access_assertions #(.COMMIT_CYC(COMMIT_CYC)) ck (
  .mclk(mclk), .sys_rst(sys_rst), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .nv_busy(nv_busy));
